// [sfc_pkg.sv]
// Package: constants and types for the SR-IOV function configuration block
package sfc_pkg;
   // Register bus offsets (word indices are byte addresses / 4)
   localparam logic [7:0] OFS_VF_CTRL = 8'h00;
   localparam logic [7:0] OFS_VF_STAT = 8'h04;
   localparam logic [7:0] OFS_SRIOV_ID0 = 8'h08;
   localparam logic [7:0] OFS_SRIOV_ID1 = 8'h0C;
   localparam logic [7:0] OFS_PAGE_SZ0 = 8'h10;
   localparam logic [7:0] OFS_PAGE_SZ1 = 8'h14;
   localparam logic [7:0] OFS_BAR_BASE = 8'h20;
   localparam logic [7:0] OFS_BAR_STAT = 8'h50;
   localparam logic [7:0] OFS_MSIX = 8'h54;
   localparam logic [7:0] OFS_CAP_CTRL = 8'h58;
   localparam logic [7:0] OFS_CAP_LINK = 8'h5C;
   localparam logic [7:0] OFS_PM_CTRL = 8'h60;
   // Function numbering
   localparam logic [7:0] FN_PHYS_ZERO = 8'h00;
   localparam logic [7:0] FN_PHYS_ONE = 8'h01;
   localparam logic [7:0] FN_VF_FIRST = 8'h40;
   localparam logic [7:0] FN_VF_LAST = 8'h45;
   localparam logic [7:0] FN_ONE_OFS_BASE = 8'h3F;
   localparam logic [3:0] MAX_VFS = 4'h6;
   // Capability offsets in extended config space
   localparam logic [11:0] CAP_AER = 12'h100;
   localparam logic [11:0] CAP_ARI = 12'h140;
   localparam logic [11:0] CAP_SRIOV = 12'h150;
   localparam logic [11:0] CAP_DSN = 12'h190;
   localparam logic [11:0] CAP_VC = 12'h1A0;
   localparam logic [11:0] CAP_VSEC = 12'h1C0;
   // BAR config word fields
   localparam int BAR_EN_BIT = 0;
   localparam int BAR_IO_BIT = 1;
   localparam int BAR_64_BIT = 2;
   localparam int BAR_PF_BIT = 3;
   localparam int BAR_SZ_LSB = 8;
   localparam logic [5:0] SZ_MIN_STD = 6'h07;
   localparam logic [5:0] SZ_MIN_LEG = 6'h04;
   localparam logic [5:0] SZ_MAX_32 = 6'h1F;
   // Reset values
   localparam logic [3:0] SRIOV_VER_RST = 4'h1;
   localparam logic [15:0] VF_DEVID_RST = 16'h0000;
   localparam logic [31:0] PAGE_SZ_RST = 32'h0000_0553;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
   // Power states
   typedef enum logic [1:0] {
      SFC_D0, SFC_D1, SFC_D2, SFC_D3
   } sfc_pstate_t;
endpackage : sfc_pkg

// [sfc_config_space.sv]
// SR-IOV function numbering, BAR checks, capability chain and wake gating
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/1ps
module sfc_config_space #(
   parameter int NUM_BARS = 6,
   parameter bit ROOT_PORT = 1'b0
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Register port
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o,
   // Request claim check
   input wire logic req_valid_i,
   input wire logic req_io_i,
   input wire logic [2:0] req_bar_i,
   output logic req_claim_o,
   // Application side
   input wire logic [63:0] serial_number_i,
   input wire logic [1:0] pm_state_i,
   input wire logic [1:0] pm_event_i,
   output logic [1:0] power_wake_request_o,
   output logic [63:0] serial_number_o
);
   // Elaboration check: the logic only serves a six-slot endpoint bank
   if (NUM_BARS != 6 || ROOT_PORT) begin : g_param_check
      $error("sfc_config_space: only six-slot endpoint is served");
   end

   typedef struct packed {
      logic [3:0] count_of_fn_zero_virtuals;
      logic [3:0] vf_one;
      logic [3:0] sriov_ver;
      logic [15:0] vf_devid0;
      logic [15:0] vf_devid1;
      logic [31:0] page_sz0;
      logic [31:0] page_sz1;
      logic [11:0][15:0] bar_cfg;
      logic legacy;
      logic [31:0] msix;
      logic [4:0] cap_en;
      logic [7:0] pm_wake_en;
      logic [1:0] wake;
      logic [63:0] serial;
      logic claim;
      logic [31:0] rdata;
   } sfc_state_t;

   sfc_state_t st_q, st_d;
   // Kept out of the state struct: it runs on the raw reset, the rest not
   logic [1:0] rst_sync_q;
   logic rst_n;
   assign rst_n = rst_sync_q[1];

   // Reset release through two flops so the release is glitch free
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   // Legal BAR check used for both functions' banks
   function automatic logic [5:0] bar_legal(input logic [5:0][15:0] b,
                                            input logic leg);
      logic [5:0] ok;
      logic [5:0] sz;
      ok = 6'h3F;
      for (int i = 0; i < 6; i++) begin
         sz = b[i][sfc_pkg::BAR_SZ_LSB +: 6];
         if (b[i][sfc_pkg::BAR_EN_BIT]) begin
            if (b[i][sfc_pkg::BAR_IO_BIT] && (!leg ||
                b[i][sfc_pkg::BAR_64_BIT] || b[i][sfc_pkg::BAR_PF_BIT]))
               ok[i] = 1'b0;
            if (sz < (leg ? sfc_pkg::SZ_MIN_LEG : sfc_pkg::SZ_MIN_STD))
               ok[i] = 1'b0;
            if (!b[i][sfc_pkg::BAR_64_BIT] && sz > sfc_pkg::SZ_MAX_32)
               ok[i] = 1'b0;
            if (b[i][sfc_pkg::BAR_64_BIT] && i == 5)
               ok[i] = 1'b0;
            if (!leg && i != 5 && b[i][sfc_pkg::BAR_PF_BIT] &&
                !b[i][sfc_pkg::BAR_64_BIT])
               ok[i] = 1'b0;
         end
      end
      return ok;
   endfunction : bar_legal

   // Slot usable as its own BAR: not the upper half of a 64-bit pair
   function automatic logic [5:0] bar_usable(input logic [5:0][15:0] b);
      logic [5:0] u;
      u[0] = b[0][sfc_pkg::BAR_EN_BIT];
      for (int i = 1; i < 6; i++) begin
         u[i] = b[i][sfc_pkg::BAR_EN_BIT] && !(b[i-1][sfc_pkg::BAR_EN_BIT]
                && b[i-1][sfc_pkg::BAR_64_BIT] && u[i-1]);
      end
      return u;
   endfunction : bar_usable

   logic [5:0][15:0] bank0, bank1;
   logic [5:0] use0, legal0, use1, legal1;
   logic [7:0] first_off0, first_off1, vf_total;
   logic [4:0] cap_eff;
   logic [11:0] nxt_aer, nxt_ari, nxt_sriov, nxt_dsn, nxt_vc;
   assign bank0 = st_q.bar_cfg[5:0];
   assign bank1 = st_q.bar_cfg[11:6];
   assign use0 = bar_usable(bank0);
   assign use1 = bar_usable(bank1);
   assign legal0 = bar_legal(bank0, st_q.legacy);
   assign legal1 = bar_legal(bank1, st_q.legacy);
   assign vf_total = {4'h0, st_q.count_of_fn_zero_virtuals}
                     + {4'h0, st_q.vf_one};
   // First VF offset = first VF number minus PF number
   assign first_off0 = (st_q.count_of_fn_zero_virtuals != 4'h0) ?
      sfc_pkg::FN_VF_FIRST - sfc_pkg::FN_PHYS_ZERO : 8'h00;
   assign first_off1 = (st_q.vf_one != 4'h0) ? sfc_pkg::FN_ONE_OFS_BASE
      + {4'h0, st_q.count_of_fn_zero_virtuals} : 8'h00;

   // Effective enables: bit0 SR-IOV, 1 ARI, 2 DSN, 3 VC, 4 vendor
   always_comb begin
      cap_eff = st_q.cap_en;
      cap_eff[1] = st_q.cap_en[1] | st_q.cap_en[0];
      cap_eff[3] = st_q.cap_en[3] & st_q.cap_en[2];
      cap_eff[4] = st_q.cap_en[4] & st_q.cap_en[2];
   end

   // Chain built from the tail so each header names the next enabled one
   always_comb begin
      nxt_vc = cap_eff[4] ? sfc_pkg::CAP_VSEC : 12'h000;
      nxt_dsn = cap_eff[3] ? sfc_pkg::CAP_VC : nxt_vc;
      nxt_sriov = cap_eff[2] ? sfc_pkg::CAP_DSN : nxt_dsn;
      nxt_ari = cap_eff[0] ? sfc_pkg::CAP_SRIOV : nxt_sriov;
      nxt_aer = cap_eff[1] ? sfc_pkg::CAP_ARI : nxt_ari;
   end

   // Next-state logic for everything except the reset synchroniser
   always_comb begin
      st_d = st_q;
      if (wr_i) begin
         case (addr_i)
            sfc_pkg::OFS_VF_CTRL: begin
               // Refuse totals above six; function zero's VFs come first
               if ({4'h0, wdata_i[3:0]} + {4'h0, wdata_i[7:4]}
                   <= {4'h0, sfc_pkg::MAX_VFS}) begin
                  st_d.count_of_fn_zero_virtuals = wdata_i[3:0];
                  st_d.vf_one = wdata_i[7:4];
               end
               st_d.sriov_ver = wdata_i[11:8];
               st_d.legacy = wdata_i[12];
            end
            sfc_pkg::OFS_SRIOV_ID0: st_d.vf_devid0 = wdata_i[15:0];
            sfc_pkg::OFS_SRIOV_ID1: st_d.vf_devid1 = wdata_i[15:0];
            sfc_pkg::OFS_PAGE_SZ0: st_d.page_sz0 = wdata_i;
            sfc_pkg::OFS_PAGE_SZ1: st_d.page_sz1 = wdata_i;
            sfc_pkg::OFS_MSIX: st_d.msix = wdata_i;
            sfc_pkg::OFS_CAP_CTRL: st_d.cap_en = wdata_i[4:0];
            sfc_pkg::OFS_PM_CTRL: st_d.pm_wake_en = wdata_i[7:0];
            default: begin
               for (int i = 0; i < 12; i++) begin
                  if (addr_i == sfc_pkg::OFS_BAR_BASE + 8'(4 * i))
                     st_d.bar_cfg[i] = wdata_i[15:0];
               end
            end
         endcase
      end
      // Read data valid the cycle after the strobe only
      st_d.rdata = sfc_pkg::RDATA_ZERO;
      if (rd_i) begin
         case (addr_i)
            sfc_pkg::OFS_VF_CTRL: st_d.rdata = {19'h0, st_q.legacy,
               st_q.sriov_ver, st_q.vf_one, st_q.count_of_fn_zero_virtuals};
            sfc_pkg::OFS_VF_STAT: st_d.rdata = {first_off1, first_off0,
               sfc_pkg::FN_PHYS_ONE, sfc_pkg::FN_PHYS_ZERO};
            sfc_pkg::OFS_SRIOV_ID0: st_d.rdata = {16'h0, st_q.vf_devid0};
            sfc_pkg::OFS_SRIOV_ID1: st_d.rdata = {16'h0, st_q.vf_devid1};
            sfc_pkg::OFS_PAGE_SZ0: st_d.rdata = st_q.page_sz0;
            sfc_pkg::OFS_PAGE_SZ1: st_d.rdata = st_q.page_sz1;
            sfc_pkg::OFS_BAR_STAT: st_d.rdata = {4'h0, legal1, use1,
               2'b00, legal0, 2'b00, use0};
            sfc_pkg::OFS_MSIX: st_d.rdata = st_q.msix;
            sfc_pkg::OFS_CAP_CTRL: st_d.rdata = {27'h0, cap_eff};
            sfc_pkg::OFS_CAP_LINK: st_d.rdata = {8'h0, nxt_ari,
               nxt_aer};
            sfc_pkg::OFS_PM_CTRL: st_d.rdata = {24'h0, st_q.pm_wake_en};
            default: begin
               for (int i = 0; i < 12; i++) begin
                  if (addr_i == sfc_pkg::OFS_BAR_BASE + 8'(4 * i))
                     st_d.rdata = {16'h0, st_q.bar_cfg[i]};
               end
            end
         endcase
      end
      // Claim: usable, legal BAR of matching type in function zero's bank
      st_d.claim = req_valid_i && req_bar_i < 3'd6
         && use0[req_bar_i] && legal0[req_bar_i]
         && (bank0[req_bar_i][sfc_pkg::BAR_IO_BIT] == req_io_i);
      // Wake per function gated by the wake-capable state mask
      for (int f = 0; f < 2; f++) begin
         st_d.wake[f] = pm_event_i[f]
            && st_q.pm_wake_en[4 * f + int'(pm_state_i)];
      end
      // Serial number only presented when DSN is on
      st_d.serial = cap_eff[2] ? serial_number_i : 64'h0;
   end

   // State register, sync-released reset
   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q.count_of_fn_zero_virtuals <= 4'h0;
         st_q.vf_one <= 4'h0;
         st_q.sriov_ver <= sfc_pkg::SRIOV_VER_RST;
         st_q.vf_devid0 <= sfc_pkg::VF_DEVID_RST;
         st_q.vf_devid1 <= sfc_pkg::VF_DEVID_RST;
         st_q.page_sz0 <= sfc_pkg::PAGE_SZ_RST;
         st_q.page_sz1 <= sfc_pkg::PAGE_SZ_RST;
         st_q.bar_cfg <= '0;
         st_q.legacy <= 1'b0;
         st_q.msix <= 32'h0000_0000;
         st_q.cap_en <= 5'h00;
         st_q.pm_wake_en <= 8'h00;
         st_q.wake <= 2'b00;
         st_q.serial <= 64'h0;
         st_q.claim <= 1'b0;
         st_q.rdata <= 32'h0000_0000;
      end else begin
         st_q.count_of_fn_zero_virtuals <= st_d.count_of_fn_zero_virtuals;
         st_q.vf_one <= st_d.vf_one;
         st_q.sriov_ver <= st_d.sriov_ver;
         st_q.vf_devid0 <= st_d.vf_devid0;
         st_q.vf_devid1 <= st_d.vf_devid1;
         st_q.page_sz0 <= st_d.page_sz0;
         st_q.page_sz1 <= st_d.page_sz1;
         st_q.bar_cfg <= st_d.bar_cfg;
         st_q.legacy <= st_d.legacy;
         st_q.msix <= st_d.msix;
         st_q.cap_en <= st_d.cap_en;
         st_q.pm_wake_en <= st_d.pm_wake_en;
         st_q.wake <= st_d.wake;
         st_q.serial <= st_d.serial;
         st_q.claim <= st_d.claim;
         st_q.rdata <= st_d.rdata;
      end
   end

   assign rdata_o = st_q.rdata;
   assign req_claim_o = st_q.claim;
   assign power_wake_request_o = st_q.wake;
   assign serial_number_o = st_q.serial;

   // Checks
   property p_vf_total;
      @(posedge mclk_i) disable iff (!rst_n)
      vf_total <= {4'h0, sfc_pkg::MAX_VFS};
   endproperty
   a_vf_total: assert property (p_vf_total)
      else $error("more than six virtual functions");
   property p_off0;
      @(posedge mclk_i) disable iff (!rst_n)
      st_q.count_of_fn_zero_virtuals != 4'h0 |-> first_off0 == 8'd64;
   endproperty
   a_off0: assert property (p_off0)
      else $error("function zero offset not 64");
   property p_off1;
      @(posedge mclk_i) disable iff (!rst_n)
      st_q.vf_one != 4'h0 |->
      first_off1 == 8'd63 + {4'h0, st_q.count_of_fn_zero_virtuals};
   endproperty
   a_off1: assert property (p_off1)
      else $error("function one offset wrong");
   property p_last_vf;
      @(posedge mclk_i) disable iff (!rst_n)
      st_q.vf_one != 4'h0 |->
      8'd1 + first_off1 + {4'h0, st_q.vf_one} - 8'd1 <= 8'd69;
   endproperty
   a_last_vf: assert property (p_last_vf)
      else $error("virtual function number beyond 69");
   property p_ari;
      @(posedge mclk_i) disable iff (!rst_n)
      st_q.cap_en[0] |-> cap_eff[1];
   endproperty
   a_ari: assert property (p_ari)
      else $error("ARI missing with SR-IOV on");
   property p_vc_dsn;
      @(posedge mclk_i) disable iff (!rst_n)
      (cap_eff[3] || cap_eff[4]) |-> cap_eff[2];
   endproperty
   a_vc_dsn: assert property (p_vc_dsn)
      else $error("VC or vendor cap without DSN");
   property p_chain_end;
      @(posedge mclk_i) disable iff (!rst_n)
      cap_eff == 5'h00 |-> nxt_aer == 12'h000;
   endproperty
   a_chain_end: assert property (p_chain_end)
      else $error("chain not terminated");
   property p_wake;
      @(posedge mclk_i) disable iff (!rst_n)
      (pm_event_i[0] && !st_q.pm_wake_en[pm_state_i]) |=>
      !power_wake_request_o[0];
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake in non-wake-capable state");
   property p_claim;
      @(posedge mclk_i) disable iff (!rst_n)
      (req_valid_i && req_bar_i < 3'd6 &&
       bank0[req_bar_i][sfc_pkg::BAR_IO_BIT] != req_io_i) |=> !req_claim_o;
   endproperty
   a_claim: assert property (p_claim)
      else $error("BAR claimed wrong space type");
   property p_pair;
      @(posedge mclk_i) disable iff (!rst_n)
      (use0[0] && bank0[0][sfc_pkg::BAR_64_BIT]) |-> !use0[1];
   endproperty
   a_pair: assert property (p_pair)
      else $error("upper slot of 64-bit BAR offered");
   property p_fn_numbers;
      @(posedge mclk_i) disable iff (!rst_n)
      (rd_i && addr_i == sfc_pkg::OFS_VF_STAT) |=>
      rdata_o[15:0] == {sfc_pkg::FN_PHYS_ONE, sfc_pkg::FN_PHYS_ZERO};
   endproperty
   a_fn_numbers: assert property (p_fn_numbers)
      else $error("physical function numbers wrong");
   property p_serial_off;
      @(posedge mclk_i) disable iff (!rst_n)
      !cap_eff[2] |=> serial_number_o == 64'h0000_0000_0000_0000;
   endproperty
   a_serial_off: assert property (p_serial_off)
      else $error("serial shown with capability off");
   c_rd: cover property (@(posedge mclk_i) disable iff (!rst_n)
      rd_i ##1 rdata_o != 32'h0000_0000);
   c_both_vf: cover property (@(posedge mclk_i) disable iff (!rst_n)
      st_q.count_of_fn_zero_virtuals != 4'h0 && st_q.vf_one != 4'h0);
   c_claim: cover property (@(posedge mclk_i) disable iff (!rst_n)
      req_claim_o);
   c_wake: cover property (@(posedge mclk_i) disable iff (!rst_n)
      power_wake_request_o != 2'b00);
endmodule : sfc_config_space

// [sfc_app_model.sv]
// Application-side model: serial number source and wake events
`timescale 1ns/1ps
module sfc_app_model #(
   // Arbitrary value, names no real part
   parameter logic [63:0] SERIAL = 64'h0123_4567_89ab_cdef
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Toward the block
   output logic [63:0] serial_number_o,
   output logic [1:0] pm_event_o
);
   // Serial held steady so the capability always has a value to show
   assign serial_number_o = SERIAL;
   // Wake events arrive at random, one bit per function
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pm_event_o <= 2'h0;
      end else begin
         pm_event_o <= 2'($urandom_range(3));
      end
   end
endmodule : sfc_app_model

// [testbench.sv]
// Self-checking testbench for the SR-IOV function configuration block
`timescale 1ns/1ps
module testbench;
   logic mclk_i, rst_n_i, wr_i, rd_i, req_valid_i, req_io_i, req_claim_o;
   logic [7:0] addr_i, pm;
   logic [31:0] wdata_i, rdata_o, rv;
   logic [31:0] bar [12];
   logic [31:0] dv [5];
   logic [2:0] req_bar_i;
   logic [63:0] serial_number_i, serial_number_o;
   logic [1:0] pm_state_i, pm_event_i, power_wake_request_o, e2;
   logic [3:0] c0, c1, n0, n1, ver;
   logic [4:0] ce;
   logic [5:0] en6;
   logic lg;
   int error_cnt, tests_run;
   localparam logic [7:0] AD [5] = '{sfc_pkg::OFS_SRIOV_ID0,
      sfc_pkg::OFS_SRIOV_ID1, sfc_pkg::OFS_PAGE_SZ0, sfc_pkg::OFS_PAGE_SZ1,
      sfc_pkg::OFS_MSIX};
   localparam logic [31:0] MK [5] = '{32'h0000_ffff, 32'h0000_ffff,
      32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff};

   sfc_config_space #(.NUM_BARS(6), .ROOT_PORT(1'b0)) u_sfc_config_space (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .req_valid_i(req_valid_i), .req_io_i(req_io_i),
      .req_bar_i(req_bar_i), .req_claim_o(req_claim_o),
      .serial_number_i(serial_number_i), .pm_state_i(pm_state_i),
      .pm_event_i(pm_event_i),
      .power_wake_request_o(power_wake_request_o),
      .serial_number_o(serial_number_o));
   sfc_app_model u_sfc_app_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
      .serial_number_o(serial_number_i), .pm_event_o(pm_event_i));

   // 50 MHz clock
   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end

   task automatic complete_run();
      $display("Counts: %0d checks, %0d mismatches", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input string n, input logic [63:0] s, x);
      tests_run++;
      if (s !== x) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, x, s);
      end
   endtask : chk

   // Write leaves one idle edge so the strobe is never driven twice at once
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge mclk_i);
      wr_i <= 1'b0;
      @(posedge mclk_i);
   endtask : wr

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      @(negedge mclk_i);
      d = rdata_o;
      @(posedge mclk_i);
   endtask : rd

   task automatic rchk(input string n, input logic [7:0] a,
                       input logic [31:0] x);
      logic [31:0] d;
      rd(a, d);
      chk(n, d, x);
   endtask : rchk

   task automatic setbars();
      for (int i = 0; i < 12; i++) begin
         wr(sfc_pkg::OFS_BAR_BASE + 8'(4 * i), bar[i]);
      end
   endtask : setbars

   function automatic logic [31:0] vf_stat(input logic [3:0] a, b);
      logic [7:0] o0, o1;
      o0 = (a != 4'h0) ? 8'h40 : 8'h00;
      o1 = (b != 4'h0) ? 8'h3f + {4'h0, a} : 8'h00;
      return {o1, o0, 8'h01, 8'h00};
   endfunction : vf_stat

   function automatic logic legal(input logic [31:0] c, input int s,
                                  input logic l);
      legal = 1'b1;
      if (c[1] && (!l || c[2] || c[3])) legal = 1'b0;
      if (c[13:8] < (l ? 6'h04 : 6'h07)) legal = 1'b0;
      if (!c[2] && c[13:8] > 6'h1f) legal = 1'b0;
      if (c[2] && s == 5) legal = 1'b0;
      if (!l && c[3] && !c[2] && s < 5) legal = 1'b0;
      // Disabled slots are never flagged
      if (!c[0]) legal = 1'b1;
   endfunction : legal

   // Upper half of a 64-bit pair is never offered on its own
   function automatic logic [31:0] bar_stat(input logic l);
      logic [31:0] r;
      logic up;
      r = 32'h0000_0000;
      for (int f = 0; f < 2; f++) begin
         up = 1'b0;
         for (int s = 0; s < 6; s++) begin
            r[f * 16 + s] = bar[f * 6 + s][0] && !up;
            r[(f != 0 ? 22 : 8) + s] = legal(bar[f * 6 + s], s, l);
            up = !up && bar[f * 6 + s][0] && bar[f * 6 + s][2];
         end
      end
      return r;
   endfunction : bar_stat

   // Lowest enabled capability after position k, else end of list
   function automatic logic [11:0] nxt(input logic [5:0] en, input int k);
      logic [11:0] ofs [6];
      ofs = '{sfc_pkg::CAP_AER, sfc_pkg::CAP_ARI, sfc_pkg::CAP_SRIOV,
              sfc_pkg::CAP_DSN, sfc_pkg::CAP_VC, sfc_pkg::CAP_VSEC};
      nxt = 12'h000;
      for (int i = 5; i > k; i--) if (en[i]) nxt = ofs[i];
   endfunction : nxt

   // Watchdog well beyond the expected run length
   initial begin
      #(20 * 20000);
      error_cnt++;
      complete_run();
   end

   initial begin
      void'($urandom(32'ha9e3_3ddb));
      // Start high and drop after 1 ns so every reset flop sees the edge
      {rst_n_i, wr_i, rd_i, req_valid_i, req_io_i} = 5'h10;
      {addr_i, wdata_i, req_bar_i, pm_state_i} = '0;
      #1 rst_n_i = 1'b0;
      repeat (16) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      rchk("vf_ctrl", sfc_pkg::OFS_VF_CTRL, 32'h0000_0100);
      rchk("vf_stat", sfc_pkg::OFS_VF_STAT, 32'h0000_0100);
      rchk("unmapped", 8'h18, 32'h0000_0000);
      rchk("page0", sfc_pkg::OFS_PAGE_SZ0, 32'h0000_0553);
      // Read data must drop back to zero one cycle after it stood
      @(negedge mclk_i);
      chk("rdata_idle", rdata_o, 64'h0);
      $display("done: reset values");
      {c0, c1} = 8'h00;
      for (int k = 0; k < 24; k++) begin
         {n0, n1} = {4'($urandom_range(7)), 4'($urandom_range(7))};
         if (k < 4) {n0, n1} = k == 0 ? 8'h23 : k == 1 ? 8'h60 :
                               k == 2 ? 8'h06 : 8'h43;
         {ver, lg} = 5'($urandom);
         wr(sfc_pkg::OFS_VF_CTRL, {19'h0, lg, ver, n1, n0});
         if (5'(n0) + 5'(n1) <= 5'h06) {c0, c1} = {n0, n1};
         rchk("vf_ctrl", sfc_pkg::OFS_VF_CTRL,
              {19'h0, lg, ver, c1, c0});
         rchk("vf_stat", sfc_pkg::OFS_VF_STAT,
              vf_stat(c0, c1));
      end
      $display("done: function numbering");
      for (int a = 0; a < 5; a++) dv[a] = $urandom & MK[a];
      for (int a = 0; a < 5; a++) wr(AD[a], dv[a]);
      wr(8'h18, $urandom);
      rchk("unmapped", 8'h18, 32'h0000_0000);
      for (int a = 0; a < 5; a++) begin
         rchk("field", AD[a], dv[a]);
      end
      $display("done: identity fields");
      wr(sfc_pkg::OFS_VF_CTRL, 32'h0000_1100);
      bar = '{32'h0000_0c0d, 32'h0000_0c0d, 32'h0000_0a01, 32'h0000_0403,
              32'h0000_0701, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
      setbars();
      rchk("bar_stat", sfc_pkg::OFS_BAR_STAT, bar_stat(1'b1));
      for (int i = 0; i < 12; i++) begin
         rchk("bar_cfg", sfc_pkg::OFS_BAR_BASE + 8'(4 * i), bar[i]);
      end
      // MSI-X table sits in BAR0, a memory BAR the application backs
      wr(sfc_pkg::OFS_MSIX, 32'h0000_1000);
      rchk("msix", sfc_pkg::OFS_MSIX, 32'h0000_1000);
      for (int s = 0; s < 12; s++) begin
         req_valid_i <= 1'b1;
         req_io_i <= s[0];
         req_bar_i <= 3'(s / 2);
         @(posedge mclk_i);
         req_valid_i <= 1'b0;
         @(negedge mclk_i);
         chk("claim", req_claim_o,
             s[0] ? (s / 2 == 3) : (s % 4 == 0));
         @(posedge mclk_i);
      end
      for (int k = 0; k < 16; k++) begin
         lg = 1'($urandom);
         wr(sfc_pkg::OFS_VF_CTRL, {19'h0, lg, 12'h100});
         for (int i = 0; i < 12; i++) bar[i] = {18'h0, 6'($urandom), 4'h0,
                                                4'($urandom)};
         setbars();
         rchk("bar_stat", sfc_pkg::OFS_BAR_STAT,
              bar_stat(lg));
      end
      $display("done: bar checks");
      for (int v = 0; v < 32; v++) begin
         wr(sfc_pkg::OFS_CAP_CTRL, 32'(v));
         ce = {v[4] & v[2], v[3] & v[2], v[2], v[1] | v[0], v[0]};
         rchk("cap_ctrl", sfc_pkg::OFS_CAP_CTRL, {27'h0, ce});
         en6 = {ce[4], ce[3], ce[2], ce[0], ce[1], 1'b1};
         rd(sfc_pkg::OFS_CAP_LINK, rv);
         chk("aer_next", rv[11:0], nxt(en6, 0));
         if (ce[1]) chk("ari_next", rv[23:12], nxt(en6, 1));
         chk("serial", serial_number_o,
             ce[2] ? serial_number_i : 64'h0);
      end
      $display("done: capability list");
      for (int p = 0; p < 2; p++) begin
         pm = 8'($urandom);
         wr(sfc_pkg::OFS_PM_CTRL, {24'h0, pm});
         rchk("pm_ctrl", sfc_pkg::OFS_PM_CTRL, {24'h0, pm});
         for (int k = 0; k < 40; k++) begin
            pm_state_i <= 2'($urandom_range(3));
            @(negedge mclk_i);
            e2 = pm_event_i & {pm[4 + pm_state_i], pm[pm_state_i]};
            @(negedge mclk_i);
            chk("wake", power_wake_request_o, e2);
            @(posedge mclk_i);
         end
      end
      $display("done: wake gating");
      complete_run();
   end
endmodule : testbench
